// file: twc_load_model.sv
// external loads on the two compare output pins.
// assumes each pin has a pull-down, so an undriven pin reads low.
`timescale 1ns/10ps
`default_nettype none
module twc_load_model (
	input wire logic val_a,
	input wire logic oe_a,
	input wire logic val_b,
	input wire logic oe_b,
	output logic lvl_a,
	output logic lvl_b
);
	assign lvl_a = oe_a ? val_a : 1'b0;
	assign lvl_b = oe_b ? val_b : 1'b0;
endmodule : twc_load_model
`default_nettype wire

// file: twc_pkg.sv
// constants for the timer waveform control block: register map, fields,
// mode codes and fixed TOP values.
// assumes a 32-bit avalon-mm slave port with byte addresses.
package twc_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [7:0] ADDR_CTL_A = 8'h80;
	localparam logic [7:0] ADDR_CTL_B = 8'h84;
	localparam logic [7:0] ADDR_CMP_A = 8'h88;
	localparam logic [7:0] ADDR_CMP_B = 8'h8c;
	localparam logic [7:0] ADDR_CAPTURE = 8'h90;
	localparam logic [7:0] ADDR_COUNTER = 8'h94;
	localparam logic [7:0] ADDR_PIN_CFG = 8'h98;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h9c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha0;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'ha4;
	// ==========================================================
	// field layout
	localparam int CTL_A_ACT_A_LSB = 6;
	localparam int CTL_A_ACT_B_LSB = 4;
	localparam logic [7:0] CTL_A_WR_MASK = 8'hf3;
	localparam int CTL_B_MODE_HI_LSB = 3;
	localparam int CTL_B_RUN_BIT = 0;
	localparam int PIN_DIR_A = 0;
	localparam int PIN_DIR_B = 1;
	localparam int PIN_PORT_A = 2;
	localparam int PIN_PORT_B = 3;
	localparam int EV_OVF = 0;
	localparam int EV_MATCH_A = 1;
	localparam int EV_MATCH_B = 2;
	localparam int EV_CAPTURE = 3;
	// ==========================================================
	// reset values and counter limits
	localparam logic [7:0] CTL_A_RESET = 8'h00;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	// ==========================================================
	// waveform modes
	localparam logic [3:0] WM_NORMAL = 4'h0;
	localparam logic [3:0] WM_PC8 = 4'h1;
	localparam logic [3:0] WM_PC9 = 4'h2;
	localparam logic [3:0] WM_PC10 = 4'h3;
	localparam logic [3:0] WM_CTC_CMP = 4'h4;
	localparam logic [3:0] WM_FAST8 = 4'h5;
	localparam logic [3:0] WM_FAST9 = 4'h6;
	localparam logic [3:0] WM_FAST10 = 4'h7;
	localparam logic [3:0] WM_PFC_CAP = 4'h8;
	localparam logic [3:0] WM_PFC_CMP = 4'h9;
	localparam logic [3:0] WM_PC_CAP = 4'ha;
	localparam logic [3:0] WM_PC_CMP = 4'hb;
	localparam logic [3:0] WM_CTC_CAP = 4'hc;
	localparam logic [3:0] WM_FAST_CAP = 4'he;
	localparam logic [3:0] WM_FAST_CMP = 4'hf;
	// output action codes
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	typedef enum logic [1:0] {WF_PLAIN, WF_FAST, WF_DUAL} twc_wave_t;
	typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOTTOM} twc_upd_t;
endpackage : twc_pkg

// file: twc_timer.sv
// 16-bit timer with waveform mode select and two compare outputs.
// assumes an avalon-mm master with waitrequest; the timer counts on
// every clock while the run bit is set.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - nonzero action field connects compare output
// - pin driven only when direction selects output
// - non-pwm: off, toggle, clear, set on match
// - fast 10: clear on match, set at bottom
// - fast 11: set on match, clear at bottom
// - fast 01: toggle A only modes 14/15
// - fast: compare equals top, act at top
// - dual 01: toggle A only modes 9/11
// - dual 10: clear up-match, set down-match
// - dual 11: set up-match, clear down-match
// - four-bit mode split over two registers
// - modes 0, 4, 12: immediate update, flag MAX
// - phase correct: update at top, flag bottom
// - modes 8, 9: update and flag at bottom
// - fast: update bottom, flag top, 13 reserved
// - dual slope up then down, top once
// - capture top disables capture input
module twc_timer (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic CAPTURE_INPUT_PIN,
	output logic COMPARE_OUTPUT_A,
	output logic COMPARE_OUTPUT_A_OE,
	output logic COMPARE_OUTPUT_B,
	output logic COMPARE_OUTPUT_B_OE,
	output logic IRQ
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] ctl_a;
		logic [1:0] mode_hi;
		logic run;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] buf_a;
		logic [15:0] buf_b;
		logic [15:0] cap;
		logic [15:0] cnt;
		logic up;
		logic blk;
		logic oc_a;
		logic oc_b;
		logic [3:0] pin_cfg;
		logic [3:0] sts;
		logic [3:0] ien;
		logic cap_s1;
		logic cap_s2;
		logic cap_s3;
		logic waitreq;
		logic [31:0] rdata;
		logic out_a;
		logic oe_a;
		logic out_b;
		logic oe_b;
		logic irq;
	} twc_state_t;

	twc_state_t s_q;
	twc_state_t s_d;

	// ==========================================================
	// helpers
	function automatic logic act_connected(input logic [1:0] act,
		input logic is_a, input logic [3:0] mode,
		input twc_pkg::twc_wave_t wf);
		logic ok;
		ok = (act != twc_pkg::ACT_OFF);
		// toggle under pwm reaches channel a only in a few modes
		if (act == twc_pkg::ACT_TOGGLE) begin
			if (wf == twc_pkg::WF_FAST) begin
				ok = is_a && (mode == twc_pkg::WM_FAST_CAP ||
					mode == twc_pkg::WM_FAST_CMP);
			end else if (wf == twc_pkg::WF_DUAL) begin
				ok = is_a && (mode == twc_pkg::WM_PFC_CMP ||
					mode == twc_pkg::WM_PC_CMP);
			end
		end
		return ok;
	endfunction : act_connected

	function automatic logic next_oc(input logic oc, input logic [1:0] act,
		input logic conn, input twc_pkg::twc_wave_t wf,
		input logic match, input logic at_top,
		input logic up, input logic cmp_is_top);
		logic v;
		v = oc;
		if (conn) begin
			case (wf)
				twc_pkg::WF_PLAIN: begin
					if (match) begin
						case (act)
							twc_pkg::ACT_TOGGLE: v = ~oc;
							twc_pkg::ACT_CLEAR: v = 1'b0;
							twc_pkg::ACT_SET: v = 1'b1;
							default: v = oc;
						endcase
					end
				end
				twc_pkg::WF_FAST: begin
					if (act == twc_pkg::ACT_TOGGLE) begin
						if (match) begin
							v = ~oc;
						end
					end else if (cmp_is_top) begin
						// a compare at top would collide with the wrap
						if (at_top) begin
							v = (act == twc_pkg::ACT_CLEAR);
						end
					end else if (match) begin
						v = (act == twc_pkg::ACT_SET);
					end else if (at_top) begin
						// the bottom level is taken as the counter wraps,
						// so it already stands while the counter reads zero
						v = (act == twc_pkg::ACT_CLEAR);
					end
				end
				default: begin
					if (match) begin
						if (act == twc_pkg::ACT_TOGGLE) begin
							v = ~oc;
						end else if (act == twc_pkg::ACT_CLEAR) begin
							v = ~up;
						end else begin
							v = up;
						end
					end
				end
			endcase
		end
		return v;
	endfunction : next_oc

	// ==========================================================
	// mode decode
	logic [3:0] mode;
	twc_pkg::twc_wave_t wf;
	twc_pkg::twc_upd_t upd;
	logic [15:0] top;
	logic cap_top;

	always_comb begin
		mode = {s_q.mode_hi, s_q.ctl_a[1:0]};
		wf = twc_pkg::WF_PLAIN;
		upd = twc_pkg::UPD_NOW;
		top = twc_pkg::CNT_MAX;
		cap_top = 1'b0;
		case (mode)
			twc_pkg::WM_PC8, twc_pkg::WM_PC9, twc_pkg::WM_PC10,
			twc_pkg::WM_PC_CAP, twc_pkg::WM_PC_CMP: begin
				wf = twc_pkg::WF_DUAL;
				upd = twc_pkg::UPD_TOP;
			end
			twc_pkg::WM_PFC_CAP, twc_pkg::WM_PFC_CMP: begin
				wf = twc_pkg::WF_DUAL;
				upd = twc_pkg::UPD_BOTTOM;
			end
			twc_pkg::WM_FAST8, twc_pkg::WM_FAST9, twc_pkg::WM_FAST10,
			twc_pkg::WM_FAST_CAP, twc_pkg::WM_FAST_CMP: begin
				wf = twc_pkg::WF_FAST;
				upd = twc_pkg::UPD_BOTTOM;
			end
			default: begin
				// reserved mode 13 falls through to a plain up-counter
				wf = twc_pkg::WF_PLAIN;
			end
		endcase
		case (mode)
			twc_pkg::WM_PC8, twc_pkg::WM_FAST8: top = twc_pkg::TOP_8BIT;
			twc_pkg::WM_PC9, twc_pkg::WM_FAST9: top = twc_pkg::TOP_9BIT;
			twc_pkg::WM_PC10, twc_pkg::WM_FAST10: top = twc_pkg::TOP_10BIT;
			twc_pkg::WM_CTC_CMP, twc_pkg::WM_PFC_CMP, twc_pkg::WM_PC_CMP,
			twc_pkg::WM_FAST_CMP: top = s_q.cmp_a;
			twc_pkg::WM_PFC_CAP, twc_pkg::WM_PC_CAP, twc_pkg::WM_CTC_CAP,
			twc_pkg::WM_FAST_CAP: begin
				top = s_q.cap;
				cap_top = 1'b1;
			end
			default: top = twc_pkg::CNT_MAX;
		endcase
	end

	// ==========================================================
	// next state
	logic at_top;
	logic at_bot;
	logic match_a;
	logic match_b;
	logic conn_a;
	logic conn_b;
	logic bus_wr;
	logic [3:0] ev;
	logic [1:0] act_a;
	logic [1:0] act_b;

	always_comb begin
		s_d = s_q;
		act_a = s_q.ctl_a[twc_pkg::CTL_A_ACT_A_LSB +: 2];
		act_b = s_q.ctl_a[twc_pkg::CTL_A_ACT_B_LSB +: 2];
		at_top = (s_q.cnt == top);
		at_bot = (s_q.cnt == twc_pkg::CNT_BOTTOM);
		match_a = s_q.run && !s_q.blk && (s_q.cnt == s_q.cmp_a);
		match_b = s_q.run && !s_q.blk && (s_q.cnt == s_q.cmp_b);
		conn_a = act_connected(act_a, 1'b1, mode, wf);
		conn_b = act_connected(act_b, 1'b0, mode, wf);
		ev = 4'h0;
		s_d.blk = 1'b0;

		// counter, overflow and compare updates
		if (s_q.run) begin
			if (wf == twc_pkg::WF_DUAL) begin
				// turn at either end so each end value stands one clock
				if (s_q.up && at_top) begin
					s_d.up = 1'b0;
					s_d.cnt = s_q.cnt - twc_pkg::CNT_ONE;
				end else if (!s_q.up && at_bot) begin
					s_d.up = 1'b1;
					s_d.cnt = s_q.cnt + twc_pkg::CNT_ONE;
					ev[twc_pkg::EV_OVF] = 1'b1;
				end else if (s_q.up) begin
					s_d.cnt = s_q.cnt + twc_pkg::CNT_ONE;
				end else begin
					s_d.cnt = s_q.cnt - twc_pkg::CNT_ONE;
				end
			end else begin
				s_d.up = 1'b1;
				if (at_top) begin
					s_d.cnt = twc_pkg::CNT_BOTTOM;
				end else begin
					s_d.cnt = s_q.cnt + twc_pkg::CNT_ONE;
				end
				if (wf == twc_pkg::WF_FAST) begin
					ev[twc_pkg::EV_OVF] = at_top;
				end else begin
					ev[twc_pkg::EV_OVF] =
						(s_q.cnt == twc_pkg::CNT_MAX);
				end
			end
			if ((upd == twc_pkg::UPD_TOP && at_top) ||
				(upd == twc_pkg::UPD_BOTTOM && at_bot)) begin
				s_d.cmp_a = s_q.buf_a;
				s_d.cmp_b = s_q.buf_b;
			end
		end
		if (upd == twc_pkg::UPD_NOW) begin
			s_d.cmp_a = s_q.buf_a;
			s_d.cmp_b = s_q.buf_b;
		end

		// waveform outputs
		if (s_q.run) begin
			s_d.oc_a = next_oc(s_q.oc_a, act_a, conn_a, wf, match_a,
				at_top, s_q.up, s_q.cmp_a == top);
			s_d.oc_b = next_oc(s_q.oc_b, act_b, conn_b, wf, match_b,
				at_top, s_q.up, s_q.cmp_b == top);
		end
		ev[twc_pkg::EV_MATCH_A] = match_a;
		ev[twc_pkg::EV_MATCH_B] = match_b;

		// capture input, rising edge, disabled when it defines top
		s_d.cap_s1 = CAPTURE_INPUT_PIN;
		s_d.cap_s2 = s_q.cap_s1;
		s_d.cap_s3 = s_q.cap_s2;
		if (!cap_top && s_q.cap_s2 && !s_q.cap_s3) begin
			s_d.cap = s_q.cnt;
			ev[twc_pkg::EV_CAPTURE] = 1'b1;
		end

		// bus slave: one wait cycle, then the access completes
		// waitrequest is registered, so every access spans two edges
		bus_wr = AVS_WRITE && !s_q.waitreq;
		s_d.waitreq = !((AVS_READ || AVS_WRITE) && s_q.waitreq);
		if (AVS_READ && s_q.waitreq) begin
			s_d.rdata = 32'h0000_0000;
			if (AVS_ADDRESS == twc_pkg::ADDR_CTL_A) begin
				s_d.rdata[7:0] = s_q.ctl_a;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CTL_B) begin
				s_d.rdata[twc_pkg::CTL_B_MODE_HI_LSB +: 2] = s_q.mode_hi;
				s_d.rdata[twc_pkg::CTL_B_RUN_BIT] = s_q.run;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CMP_A) begin
				s_d.rdata[15:0] = s_q.buf_a;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CMP_B) begin
				s_d.rdata[15:0] = s_q.buf_b;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CAPTURE) begin
				s_d.rdata[15:0] = s_q.cap;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_COUNTER) begin
				s_d.rdata[15:0] = s_q.cnt;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_PIN_CFG) begin
				s_d.rdata[3:0] = s_q.pin_cfg;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_IRQ_STATUS) begin
				s_d.rdata[3:0] = s_q.sts;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_IRQ_ENABLE) begin
				s_d.rdata[3:0] = s_q.ien;
			end
		end
		if (bus_wr) begin
			if (AVS_ADDRESS == twc_pkg::ADDR_CTL_A) begin
				s_d.ctl_a = AVS_WRITEDATA[7:0] &
					twc_pkg::CTL_A_WR_MASK;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CTL_B) begin
				s_d.mode_hi =
					AVS_WRITEDATA[twc_pkg::CTL_B_MODE_HI_LSB +: 2];
				s_d.run = AVS_WRITEDATA[twc_pkg::CTL_B_RUN_BIT];
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CMP_A) begin
				s_d.buf_a = AVS_WRITEDATA[15:0];
			end else if (AVS_ADDRESS == twc_pkg::ADDR_CMP_B) begin
				s_d.buf_b = AVS_WRITEDATA[15:0];
			end else if (AVS_ADDRESS == twc_pkg::ADDR_COUNTER) begin
				// a loaded value equal to a compare must not fire next clock
				s_d.cnt = AVS_WRITEDATA[15:0];
				s_d.blk = 1'b1;
			end else if (AVS_ADDRESS == twc_pkg::ADDR_PIN_CFG) begin
				s_d.pin_cfg = AVS_WRITEDATA[3:0];
			end else if (AVS_ADDRESS == twc_pkg::ADDR_IRQ_ENABLE) begin
				s_d.ien = AVS_WRITEDATA[3:0];
			end else if (AVS_ADDRESS == twc_pkg::ADDR_IRQ_CLEAR) begin
				s_d.sts = s_q.sts & ~AVS_WRITEDATA[3:0];
			end
		end
		// events win over a clear in the same cycle
		s_d.sts = s_d.sts | ev;
		// irq looks at the next status so it rises with the flag
		s_d.irq = |(s_d.sts & s_d.ien);

		// pin muxing
		// the direction bit alone gates the driver; the waveform keeps
		// running while the pin is released
		s_d.out_a = conn_a ? s_d.oc_a : s_q.pin_cfg[twc_pkg::PIN_PORT_A];
		s_d.out_b = conn_b ? s_d.oc_b : s_q.pin_cfg[twc_pkg::PIN_PORT_B];
		s_d.oe_a = s_q.pin_cfg[twc_pkg::PIN_DIR_A];
		s_d.oe_b = s_q.pin_cfg[twc_pkg::PIN_DIR_B];
	end

	// ==========================================================
	// registers
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '0;
			// no access may complete straight out of reset
			s_q.waitreq <= 1'b1;
			// a dual-slope run starts by counting up from bottom
			s_q.up <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign AVS_READDATA = s_q.rdata;
	assign AVS_WAITREQUEST = s_q.waitreq;
	assign COMPARE_OUTPUT_A = s_q.out_a;
	assign COMPARE_OUTPUT_A_OE = s_q.oe_a;
	assign COMPARE_OUTPUT_B = s_q.out_b;
	assign COMPARE_OUTPUT_B_OE = s_q.oe_b;
	assign IRQ = s_q.irq;
endmodule : twc_timer

`default_nettype wire

// file: twc_timer_sva.sv
// checker for the timer block: bus handshake, readback, pin enables, irq.
// assumes it is bound to twc_timer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module twc_checker (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic COMPARE_OUTPUT_A_OE,
	input wire logic COMPARE_OUTPUT_B_OE,
	input wire logic IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic rd_done;
	logic pin_wr;
	assign rd_done = AVS_READ && !AVS_WAITREQUEST;
	assign pin_wr = AVS_WRITE && !AVS_WAITREQUEST
		&& AVS_ADDRESS == twc_pkg::ADDR_PIN_CFG;
	// ====
	// bus handshake
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_ANSWER: assert property ((AVS_READ || AVS_WRITE)
		&& AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered in one cycle");
	AST_WAIT_IDLE: assert property (!AVS_READ && !AVS_WRITE
		|=> AVS_WAITREQUEST)
		else $error("waitrequest low without request");
	AST_RD_UNMAPPED: assert property (rd_done && AVS_ADDRESS == 8'hfc
		|-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	// ====
	// register and pin behaviour
	AST_CTL_UNUSED_ZERO: assert property (
		rd_done && AVS_ADDRESS == twc_pkg::ADDR_CTL_A
		|-> AVS_READDATA[31:8] == 24'h0 && AVS_READDATA[3:2] == 2'h0)
		else $error("unused control bits read nonzero");
	AST_OE_A_HOLD: assert property (
		!$past(pin_wr) && !$past(pin_wr, 2) |-> $stable(COMPARE_OUTPUT_A_OE))
		else $error("output enable a moved without direction write");
	AST_OE_B_FOLLOW: assert property (
		pin_wr |-> ##2 COMPARE_OUTPUT_B_OE == $past(AVS_WRITEDATA[1], 2))
		else $error("output enable b does not follow direction bit");
	AST_IRQ_MASKED: assert property (AVS_WRITE && !AVS_WAITREQUEST
		&& AVS_ADDRESS == twc_pkg::ADDR_IRQ_ENABLE
		&& AVS_WRITEDATA[3:0] == 4'h0 |-> ##[1:3] !IRQ)
		else $error("irq high with all sources disabled");
endmodule : twc_checker

bind twc_timer twc_checker u_chk (.CLK(CLK), .NRST(NRST),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.COMPARE_OUTPUT_A_OE(COMPARE_OUTPUT_A_OE),
	.COMPARE_OUTPUT_B_OE(COMPARE_OUTPUT_B_OE), .IRQ(IRQ));
`default_nettype wire

// file: twc_timer_tb_top.sv
// testbench for twc_timer: register access, waveform modes, irq.
// assumes the pin loads of twc_load_model and the checker bind.
`timescale 1ns/10ps
`default_nettype none
module twc_timer_tb_top;
	logic clk, nrst, av_rd, av_wr, wreq, cap, oa, oa_oe, ob, ob_oe, irq;
	logic la, lb, prev;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] m;
	logic [1:0] ac;
	int fails = 0, total_checks = 0, cycles = 0, hi, tg;
	// mode, action, compare, window, high samples, transitions
	localparam int MD[15] = '{4, 0, 0, 5, 5, 5, 1, 1, 15, 11, 9, 5, 13,
		6, 2};
	localparam int AC[15] = '{1, 3, 2, 2, 3, 2, 2, 3, 1, 1, 1, 1, 3,
		3, 2};
	localparam int CP[15] = '{3, 5, 5, 63, 63, 255, 64, 64, 7, 8, 8, 63, 5,
		127, 100};
	localparam int WN[15] = '{40, 40, 40, 256, 256, 256, 510, 510, 80,
		160, 160, 40, 40, 512, 1022};
	localparam int HI[15] = '{20, 40, 0, 64, 192, 256, 128, 382, 40, 80,
		80, 0, 40, 384, 200};
	localparam int TG[15] = '{10, 0, 0, 2, 2, 0, 2, 2, 10, 10, 10, 0, 0,
		2, 2};
	twc_timer dut (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr),
		.AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.CAPTURE_INPUT_PIN(cap), .COMPARE_OUTPUT_A(oa),
		.COMPARE_OUTPUT_A_OE(oa_oe), .COMPARE_OUTPUT_B(ob),
		.COMPARE_OUTPUT_B_OE(ob_oe), .IRQ(irq));
	twc_load_model u_load (.val_a(oa), .oe_a(oa_oe), .val_b(ob),
		.oe_b(ob_oe), .lvl_a(la), .lvl_b(lb));
	// ====
	// clock, timeout, helpers
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		av_wr <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		av_wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		av_rd <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		v = rdata;
		av_rd <= 1'b0;
	endtask : bus_rd
	// ====
	// main sequence
	initial begin
		nrst = 1'b0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		cap = 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		bus_rd(twc_pkg::ADDR_CTL_A, d);
		chk(d, 32'h0);
		bus_wr(twc_pkg::ADDR_CTL_A, 32'hff);
		bus_rd(twc_pkg::ADDR_CTL_A, d);
		chk(d, 32'hf3);
		bus_rd(8'hfc, d);
		chk(d, 32'h0);
		bus_wr(twc_pkg::ADDR_CTL_A, 32'h0);
		bus_wr(twc_pkg::ADDR_PIN_CFG, 32'h5);
		repeat (3) @(posedge clk);
		chk({30'h0, oa_oe, la}, 32'h3);
		bus_wr(twc_pkg::ADDR_CTL_A, 32'hc0);
		bus_wr(twc_pkg::ADDR_PIN_CFG, 32'h4);
		repeat (3) @(posedge clk);
		chk({30'h0, oa_oe, la}, 32'h0);
		$display("test registers and pins done");
		bus_wr(twc_pkg::ADDR_PIN_CFG, 32'hb);
		for (int i = 0; i < 15; i++) begin
			m = 4'(MD[i]);
			ac = 2'(AC[i]);
			bus_wr(twc_pkg::ADDR_CTL_B, 32'h0);
			// channel b gets toggle only where it must stay disconnected
			bus_wr(twc_pkg::ADDR_CTL_A, {24'h0, ac,
				(ac == 2'h1 && m != 4'h4) ? 2'h1 : 2'h0, 2'h0, m[1:0]});
			bus_wr(twc_pkg::ADDR_CMP_A, 32'(CP[i]));
			bus_wr(twc_pkg::ADDR_COUNTER, 32'h0);
			bus_wr(twc_pkg::ADDR_CTL_B, {27'h0, m[3:2], 3'h1});
			repeat (600) @(posedge clk);
			hi = 0;
			tg = 0;
			prev = la;
			repeat (WN[i]) begin
				@(posedge clk);
				if (la === 1'b1) hi++;
				if (la !== prev) tg++;
				prev = la;
			end
			chk(32'(hi), 32'(HI[i]));
			chk(32'(tg), 32'(TG[i]));
			if (ac == 2'h1 && m != 4'h4)
				chk({31'h0, lb}, 32'h1);
			$display("test mode %0d action %0d done", m, ac);
		end
		bus_wr(twc_pkg::ADDR_CTL_B, 32'h0);
		bus_wr(twc_pkg::ADDR_CTL_A, 32'h0);
		bus_wr(twc_pkg::ADDR_COUNTER, 32'hfff0);
		bus_wr(twc_pkg::ADDR_IRQ_CLEAR, 32'hf);
		bus_wr(twc_pkg::ADDR_CTL_B, 32'h1);
		repeat (30) @(posedge clk);
		bus_wr(twc_pkg::ADDR_CTL_B, 32'h0);
		bus_rd(twc_pkg::ADDR_IRQ_STATUS, d);
		chk(d & 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus_wr(twc_pkg::ADDR_IRQ_ENABLE, 32'h1);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus_wr(twc_pkg::ADDR_IRQ_CLEAR, 32'hf);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus_wr(twc_pkg::ADDR_IRQ_ENABLE, 32'h0);
		$display("test interrupt done");
		// capture with the counter stopped, then with capture as top
		bus_wr(twc_pkg::ADDR_COUNTER, 32'h1234);
		bus_wr(twc_pkg::ADDR_IRQ_CLEAR, 32'hf);
		cap <= 1'b1;
		repeat (6) @(posedge clk);
		cap <= 1'b0;
		bus_rd(twc_pkg::ADDR_CAPTURE, d);
		chk(d, 32'h1234);
		bus_rd(twc_pkg::ADDR_IRQ_STATUS, d);
		chk(d, 32'h8);
		bus_wr(twc_pkg::ADDR_CTL_B, 32'h18);
		bus_wr(twc_pkg::ADDR_COUNTER, 32'h4321);
		bus_wr(twc_pkg::ADDR_IRQ_CLEAR, 32'hf);
		cap <= 1'b1;
		repeat (6) @(posedge clk);
		cap <= 1'b0;
		bus_rd(twc_pkg::ADDR_CAPTURE, d);
		chk(d, 32'h1234);
		bus_rd(twc_pkg::ADDR_IRQ_STATUS, d);
		chk(d, 32'h0);
		bus_wr(twc_pkg::ADDR_CTL_B, 32'h0);
		$display("test capture done");
		tally_and_finish();
	end
endmodule : twc_timer_tb_top
`default_nettype wire
